/* File: hdl/rtcs_pkg.sv */
// shared constants and types for the rtc serial slave port
package rtcs_pkg;
    localparam int          DATA_W       = 8;
    localparam int          PTR_W        = 8;
    localparam int          NUM_REGS     = 16;
    localparam logic [6:0]  DEV_ADDR     = 7'h68;
    localparam logic [7:0]  PTR_RESET    = 8'h00;
    localparam logic [3:0]  CNT_ZERO     = 4'h0;
    localparam logic [3:0]  CNT_BYTE     = 4'h8;
    localparam logic [3:0]  CNT_TX_LAST  = 4'h7;
    localparam int          SYNC_STAGES  = 2;
    localparam int          MCLK_MHZ     = 100;
    localparam int          SCL_STD_KHZ  = 100;
    localparam int          SCL_FAST_KHZ = 400;
    // mclk cycles in the shortest scl half period at fast mode, rounded down
    localparam int          SCL_HALF_CYC = (MCLK_MHZ * 1000) / (2 * SCL_FAST_KHZ);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_IGNORE
    } rtcs_state_t;
endpackage : rtcs_pkg

/* File: hdl/rtcs_port.sv */
// two-wire slave port giving a master pointer based access to the register file
`timescale 1ns/10ps
`default_nettype none
module rtcs_port #(
    parameter int NUM_REGS = rtcs_pkg::NUM_REGS
) (
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output var  logic                         sda_out,
    output var  logic                         sda_oe_n,
    output var  logic                         wr_valid,
    input  wire logic                         wr_ready,
    output var  logic [rtcs_pkg::PTR_W-1:0]   wr_addr,
    output var  logic [rtcs_pkg::DATA_W-1:0]  wr_data,
    output var  logic [rtcs_pkg::PTR_W-1:0]   rd_addr,
    input  wire logic [rtcs_pkg::DATA_W-1:0]  rd_data
);
    import rtcs_pkg::*;

    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(NUM_REGS - 1);

    logic [SYNC_STAGES-1:0] scl_sync_reg;
    logic [SYNC_STAGES-1:0] sda_sync_reg;
    logic                   scl_q_reg;
    logic                   sda_q_reg;
    logic                   scl_s;
    logic                   sda_s;
    logic                   start_evt;
    logic                   stop_evt;
    logic                   scl_rise;
    logic                   scl_fall;

    rtcs_state_t            state_reg;
    logic [3:0]             cnt_reg;
    logic [7:0]             sreg_reg;
    logic [7:0]             tx_reg;
    logic                   oe_n_reg;
    logic [PTR_W-1:0]       ptr_reg;
    logic [PTR_W-1:0]       ptr_next;
    logic                   ptr_phase_reg;
    logic                   dir_rd_reg;
    logic                   mack_reg;
    logic                   push_reg;
    logic [PTR_W+DATA_W-1:0] push_data_reg;
    logic                   addr_match;

    logic                   out_valid_reg;
    logic [PTR_W+DATA_W-1:0] out_reg;
    logic                   skid_valid_reg;
    logic [PTR_W+DATA_W-1:0] skid_reg;
    logic                   buf_ready;
    logic                   buf_pop;

    // both pins come from the master's domain, two flops before any use
    // three mclk of latency stays far inside a fast mode half period
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            scl_sync_reg <= '1;
            sda_sync_reg <= '1;
            scl_q_reg    <= 1'b1;
            sda_q_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[SYNC_STAGES-2:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[SYNC_STAGES-2:0], sda_in};
            scl_q_reg    <= scl_sync_reg[SYNC_STAGES-1];
            sda_q_reg    <= sda_sync_reg[SYNC_STAGES-1];
        end
    end

    assign scl_s     = scl_sync_reg[SYNC_STAGES-1];
    assign sda_s     = sda_sync_reg[SYNC_STAGES-1];
    assign start_evt = scl_s && scl_q_reg && sda_q_reg && !sda_s;
    assign stop_evt  = scl_s && scl_q_reg && !sda_q_reg && sda_s;
    assign scl_rise  = scl_s && !scl_q_reg;
    assign scl_fall  = !scl_s && scl_q_reg;
    assign addr_match = (sreg_reg[7:1] == DEV_ADDR);
    assign ptr_next  = (ptr_reg == PTR_LAST) ? '0 : ptr_reg + 1'b1;

    // protocol engine; the clock line is never driven, all timing follows scl
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= CNT_ZERO;
            sreg_reg      <= '0;
            tx_reg        <= '0;
            oe_n_reg      <= 1'b1;
            ptr_reg       <= PTR_RESET;
            ptr_phase_reg <= 1'b0;
            dir_rd_reg    <= 1'b0;
            mack_reg      <= 1'b0;
            push_reg      <= 1'b0;
            push_data_reg <= '0;
        end else begin
            push_reg <= 1'b0;
            if (start_evt) begin
                state_reg <= ST_ADDR;
                cnt_reg   <= CNT_ZERO;
                oe_n_reg  <= 1'b1;
            end else if (stop_evt) begin
                state_reg <= ST_IDLE;
                oe_n_reg  <= 1'b1;
            end else begin
                case (state_reg)
                    ST_ADDR, ST_RX: begin
                        if (scl_rise && cnt_reg != CNT_BYTE) begin
                            sreg_reg <= {sreg_reg[6:0], sda_s};
                            cnt_reg  <= cnt_reg + 1'b1;
                        end else if (scl_fall && cnt_reg == CNT_BYTE) begin
                            cnt_reg <= CNT_ZERO;
                            if (state_reg == ST_ADDR) begin
                                if (addr_match) begin
                                    dir_rd_reg    <= sreg_reg[0];
                                    ptr_phase_reg <= !sreg_reg[0];
                                    oe_n_reg      <= 1'b0;
                                    state_reg     <= ST_ACK;
                                end else begin
                                    state_reg <= ST_IGNORE;
                                end
                            end else if (ptr_phase_reg) begin
                                ptr_reg       <= sreg_reg[PTR_W-1:0];
                                ptr_phase_reg <= 1'b0;
                                oe_n_reg      <= 1'b0;
                                state_reg     <= ST_ACK;
                            end else if (buf_ready) begin
                                push_reg      <= 1'b1;
                                push_data_reg <= {ptr_reg, sreg_reg};
                                ptr_reg       <= ptr_next;
                                oe_n_reg      <= 1'b0;
                                state_reg     <= ST_ACK;
                            end else begin
                                // buffer full: refuse the byte rather than lose it
                                state_reg <= ST_IGNORE;
                            end
                        end
                    end
                    ST_ACK: begin
                        // hold low across the whole high phase, leave at the fall
                        if (scl_fall) begin
                            if (dir_rd_reg) begin
                                tx_reg    <= rd_data;
                                oe_n_reg  <= rd_data[7];
                                state_reg <= ST_TX;
                            end else begin
                                oe_n_reg  <= 1'b1;
                                state_reg <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (cnt_reg == CNT_TX_LAST) begin
                                cnt_reg   <= CNT_ZERO;
                                oe_n_reg  <= 1'b1;
                                ptr_reg   <= ptr_next;
                                mack_reg  <= 1'b0;
                                state_reg <= ST_MACK;
                            end else begin
                                cnt_reg  <= cnt_reg + 1'b1;
                                tx_reg   <= {tx_reg[6:0], 1'b0};
                                oe_n_reg <= tx_reg[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            if (sda_s) begin
                                state_reg <= ST_IGNORE;
                            end else begin
                                mack_reg <= 1'b1;
                            end
                        end else if (scl_fall && mack_reg) begin
                            tx_reg    <= rd_data;
                            oe_n_reg  <= rd_data[7];
                            state_reg <= ST_TX;
                        end
                    end
                    default: begin
                        oe_n_reg <= 1'b1;
                    end
                endcase
            end
        end
    end

    // two-entry buffer toward the register file; the skid slot absorbs a stall
    assign buf_ready = !skid_valid_reg;
    assign buf_pop   = out_valid_reg && wr_ready;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            out_valid_reg  <= 1'b0;
            out_reg        <= '0;
            skid_valid_reg <= 1'b0;
            skid_reg       <= '0;
        end else if (!out_valid_reg || buf_pop) begin
            if (skid_valid_reg) begin
                out_reg        <= skid_reg;
                out_valid_reg  <= 1'b1;
                skid_valid_reg <= 1'b0;
            end else begin
                out_reg       <= push_data_reg;
                out_valid_reg <= push_reg;
            end
        end else if (push_reg) begin
            skid_reg       <= push_data_reg;
            skid_valid_reg <= 1'b1;
        end
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = oe_n_reg;
    assign wr_valid = out_valid_reg;
    assign wr_addr  = out_reg[PTR_W+DATA_W-1:DATA_W];
    assign wr_data  = out_reg[DATA_W-1:0];
    assign rd_addr  = ptr_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_addr_ack_match: assert property (
        state_reg == ST_ADDR && !start_evt && !stop_evt && scl_fall
        && cnt_reg == CNT_BYTE && addr_match
        |=> !sda_oe_n && state_reg == ST_ACK)
        else $error("matching address not acknowledged");
    a_addr_no_match: assert property (
        state_reg == ST_ADDR && !start_evt && !stop_evt && scl_fall
        && cnt_reg == CNT_BYTE && !addr_match
        |=> sda_oe_n && state_reg == ST_IGNORE)
        else $error("foreign address was answered");
    a_ignore_released: assert property (
        state_reg == ST_IGNORE |-> sda_oe_n)
        else $error("data line driven while ignoring");
    a_sda_change_low: assert property (
        $changed(sda_oe_n) |-> !$past(scl_s) || $past(start_evt) || $past(stop_evt))
        else $error("data line moved while clock high");
    a_start_restart: assert property (
        start_evt |=> state_reg == ST_ADDR && cnt_reg == CNT_ZERO && sda_oe_n)
        else $error("start did not open address phase");
    a_stop_idle: assert property (
        stop_evt && !start_evt |=> state_reg == ST_IDLE && sda_oe_n)
        else $error("stop did not end transfer");
    a_ptr_load: assert property (
        state_reg == ST_RX && ptr_phase_reg && !start_evt && !stop_evt
        && scl_fall && cnt_reg == CNT_BYTE
        |=> rd_addr == $past(sreg_reg) && !sda_oe_n)
        else $error("pointer byte not loaded");
    a_wr_store: assert property (
        state_reg == ST_RX && !ptr_phase_reg && !start_evt && !stop_evt
        && scl_fall && cnt_reg == CNT_BYTE && buf_ready
        |=> push_reg && push_data_reg == {$past(ptr_reg), $past(sreg_reg)}
        ##0 rd_addr == (($past(ptr_reg) == PTR_LAST) ? '0 : $past(ptr_reg) + 1'b1))
        else $error("write byte not stored or pointer not stepped");
    a_tx_msb_first: assert property (
        state_reg == ST_ACK && dir_rd_reg && !start_evt && !stop_evt && scl_fall
        |=> sda_oe_n == $past(rd_data[7]) && tx_reg == $past(rd_data))
        else $error("read byte not started with msb");
    a_nack_release: assert property (
        state_reg == ST_MACK && !start_evt && !stop_evt && scl_rise && sda_s
        |=> sda_oe_n && state_reg == ST_IGNORE)
        else $error("line not released after master nack");
    a_buf_hold: assert property (
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_data) && $stable(wr_addr))
        else $error("buffered word dropped under stall");
    a_ack_held: assert property (
        state_reg == ST_ACK |-> !sda_oe_n)
        else $error("acknowledge not held low");
    a_fast_resp: assert property (
        state_reg == ST_TX && scl_fall && !start_evt && !stop_evt |=> $changed(cnt_reg))
        else $error("transmit bit not stepped after clock fall");
    a_next_byte: assert property (
        state_reg == ST_MACK && mack_reg && scl_fall && !start_evt && !stop_evt
        |=> state_reg == ST_TX && tx_reg == $past(rd_data))
        else $error("next read byte not loaded after master ack");

    c_write_byte: cover property (push_reg);
    c_read_nack: cover property (state_reg == ST_MACK && scl_rise && sda_s);
    c_foreign_addr: cover property (state_reg == ST_IGNORE);
    c_rep_start: cover property (state_reg == ST_RX && start_evt);
    c_buf_full: cover property (skid_valid_reg);
endmodule : rtcs_port
`default_nettype wire

/* File: verif/rtcs_bus_master.sv */
// behavioural two-wire bus master driving the port from outside the mclk domain
`timescale 1ns/10ps
`default_nettype none
module rtcs_bus_master (
    output var logic scl_out,
    output var logic sda_low,
    input  wire logic sda_line,
    output var int   unstable_cnt
);
    initial begin
        scl_out      = 1'b1;
        sda_low      = 1'b0;
        unstable_cnt = 0;
    end
    // asymmetric 160 ns period: 110 ns low so the device sees each fall in time
    task automatic bit_cyc(input logic b, output logic r);
        #40 sda_low = ~b;
        #70 scl_out = 1'b1;
        #10 r = sda_line;
        #40 if (sda_line !== r) unstable_cnt++;
        scl_out = 1'b0;
    endtask : bit_cyc
    // waits long enough for the device to release an ack before scl rises
    task automatic start();
        sda_low = 1'b0;
        #60 scl_out = 1'b1;
        #60 sda_low = 1'b1;
        #50 scl_out = 1'b0;
    endtask : start
    task automatic stop();
        #40 sda_low = 1'b1;
        #70 scl_out = 1'b1;
        #60 sda_low = 1'b0;
        #100;
    endtask : stop
    task automatic send_byte(input logic [7:0] d, output logic acked);
        logic a;
        for (int i = 7; i >= 0; i--) bit_cyc(d[i], a);
        bit_cyc(1'b1, a);
        acked = ~a;
    endtask : send_byte
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
        bit_cyc(last, a);
    endtask : recv_byte
endmodule : rtcs_bus_master
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the serial slave port with a register file model
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb;
    import rtcs_pkg::*;
    logic       mclk, sys_rst, wr_ready, wr_valid, sda_out, sda_oe_n, scl, m_low, ack;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data, rb;
    logic [7:0] regs [16];
    int         error_cnt, samples_checked, unstable_cnt, wr_cnt;
    // open drain wire with pull-up: low if either party pulls
    wire        sda_line = ~m_low & (sda_oe_n | sda_out);
    rtcs_port rtcs_port_inst (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));
    rtcs_bus_master rtcs_bus_master_inst (.scl_out(scl), .sda_low(m_low), .sda_line(sda_line),
        .unstable_cnt(unstable_cnt));
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    assign rd_data = regs[rd_addr[3:0]];
    always @(posedge mclk) if (wr_valid && wr_ready) begin
        regs[wr_addr[3:0]] <= wr_data;
        wr_cnt <= wr_cnt + 1;
    end
    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic sb(input logic [7:0] d, input logic exp_ack);
        rtcs_bus_master_inst.send_byte(d, ack);
        `CHK(ack, exp_ack);
    endtask : sb
    task automatic rb_chk(input logic last, input logic [7:0] exp_d);
        rtcs_bus_master_inst.recv_byte(last, rb);
        `CHK(rb, exp_d);
    endtask : rb_chk
    // pointer near the top so the third byte wraps to register 0
    task automatic t_write();
        rtcs_bus_master_inst.start();
        sb(8'hD0, 1'b1);
        sb(8'h0E, 1'b1);
        sb(8'hA5, 1'b1);
        sb(8'h3C, 1'b1);
        sb(8'h81, 1'b1);
        rtcs_bus_master_inst.stop();
        repeat (4) @(negedge mclk);
        `CHK(regs[14], 8'hA5);
        `CHK(regs[15], 8'h3C);
        `CHK(regs[0], 8'h81);
        `CHK(rd_addr, 8'h01);
    endtask : t_write
    task automatic t_read();
        rtcs_bus_master_inst.start();
        sb(8'hD0, 1'b1);
        sb(8'h0F, 1'b1);
        rtcs_bus_master_inst.start();
        sb(8'hD1, 1'b1);
        rb_chk(1'b0, 8'h3C);
        rb_chk(1'b1, 8'h81);
        rtcs_bus_master_inst.stop();
        `CHK(rd_addr, 8'h01);
        rtcs_bus_master_inst.start();
        sb(8'hD1, 1'b1);
        rb_chk(1'b1, 8'hC1);
        rtcs_bus_master_inst.stop();
        `CHK(rd_addr, 8'h02);
    endtask : t_read
    task automatic t_nomatch();
        rtcs_bus_master_inst.start();
        sb(8'hD2, 1'b0);
        sb(8'h07, 1'b0);
        rtcs_bus_master_inst.start();
        sb(8'hA1, 1'b0);
        rb_chk(1'b1, 8'hFF);
        rtcs_bus_master_inst.stop();
        `CHK(wr_cnt, 3);
        `CHK(rd_addr, 8'h02);
    endtask : t_nomatch
    // register file stalls: two words fit, the third byte is refused
    task automatic t_full();
        @(negedge mclk) wr_ready = 1'b0;
        rtcs_bus_master_inst.start();
        sb(8'hD0, 1'b1);
        sb(8'h03, 1'b1);
        sb(8'h11, 1'b1);
        sb(8'h22, 1'b1);
        sb(8'h33, 1'b0);
        sb(8'h44, 1'b0);
        rtcs_bus_master_inst.stop();
        `CHK(wr_valid, 1'b1);
        `CHK(wr_addr, 8'h03);
        @(negedge mclk) wr_ready = 1'b1;
        repeat (8) @(negedge mclk);
        `CHK(regs[3], 8'h11);
        `CHK(regs[4], 8'h22);
        `CHK(regs[5], 8'hC5);
        `CHK(wr_valid, 1'b0);
    endtask : t_full
    initial begin
        for (int i = 0; i < 16; i++) regs[i] = 8'hC0 | 8'(i);
        error_cnt = 0;
        samples_checked = 0;
        wr_cnt = 0;
        sys_rst = 1'b1;
        wr_ready = 1'b1;
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (8) @(negedge mclk);
        `CHK(sda_oe_n, 1'b1);
        `CHK(wr_valid, 1'b0);
        `CHK(rd_addr, 8'h00);
        t_write();
        t_read();
        t_nomatch();
        t_full();
        `CHK(unstable_cnt, 0);
        report_and_stop();
    end
    // whole run needs well under 100 us of bus time
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
